//--- shared/wdsw_pkg.sv
/*
   Constants, carriers and state type for the watchdog, sleep and wake
   controller. Assumes one device clock; timer and start-up counts are in its periods.
*/
package wdsw_pkg;
   // Status register placement and bit positions
   localparam logic [7:0] ADDR_CPU_STATUS_FLAGS = 8'h06;
   localparam int BIT_STACK_AVAIL = 5;
   localparam int BIT_GLOBAL_IRQ_DISABLE = 4;
   localparam int BIT_TIMEOUT = 3;
   localparam int BIT_POWERDOWN = 2;
   localparam int BIT_POWERON = 1;
   localparam int BIT_BROWNOUT = 0;
   localparam logic GLOBAL_IRQ_DISABLE_RST = 1'h1;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Postscale select encodings
   localparam logic [1:0] PS_SEL_1 = 2'h3;
   localparam logic [1:0] PS_SEL_256 = 2'h2;
   localparam logic [1:0] PS_SEL_64 = 2'h1;
   localparam logic [1:0] PS_SEL_TIMER = 2'h0;
   // Last postscaler index before a timeout (postscale minus one)
   localparam logic [7:0] PS_LAST_1 = 8'h00;
   localparam logic [7:0] PS_LAST_64 = 8'h3F;
   localparam logic [7:0] PS_LAST_256 = 8'hFF;

   // Oscillator mode encodings
   localparam logic [1:0] OSC_LF = 2'h0;
   localparam logic [1:0] OSC_RC = 2'h1;
   localparam logic [1:0] OSC_XT = 2'h2;
   localparam logic [1:0] OSC_EC = 2'h3;

   // Timing, in device clock periods (Tosc), nanoseconds or milliseconds
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIMER_OVF_TOSC = 65536;
   localparam int OST_TOSC = 1024;
   localparam int OST_CYCLES = OST_TOSC;
   localparam int POWERUP_DELAY_TIMER_MS = 96;
   localparam int WDT_NOMINAL_MS = 12;
   localparam logic [7:0] POWERUP_DELAY_TIMER_PS_LAST = 8'((POWERUP_DELAY_TIMER_MS / WDT_NOMINAL_MS) - 1);
   localparam int CNT_W = 16;
   localparam logic [15:0] TIMER_LAST = 16'(TIMER_OVF_TOSC - 1);

   // Wake-capable interrupt sources
   localparam int WAKE_EXT_PIN = 0;
   localparam int WAKE_PORTB_CHANGE = 1;
   localparam int WAKE_TIMER0_CLK = 2;
   localparam int WAKE_CAPTURE = 3;
   localparam int WAKE_SYNC_TX = 4;
   localparam int WAKE_SYNC_RX = 5;
   localparam int WAKE_ADC_DONE = 6;
   localparam int WAKE_SPI_SLAVE = 7;
   localparam int WAKE_I2C_SLAVE_RX = 8;
   localparam int WAKE_SRC_N = 9;

   typedef struct packed {
      logic [1:0] osc_mode;
      logic [1:0] watchdog_postscale_select;
   } wdsw_cfg_t;

   typedef struct packed {
      logic [WAKE_SRC_N-1:0] enable;
      logic [WAKE_SRC_N-1:0] flag;
   } wdsw_irq_t;

   typedef enum logic [2:0] {
      ST_POWERUP_DELAY_TIMER,
      ST_RESET,
      ST_RUN,
      ST_SLEEP,
      ST_OST
   } wdsw_state_t;
endpackage

//--- hw/wdsw_top.sv
/*
   Watchdog timer, postscaler, power-up delay and sleep/wake sequencing.
   Assumes the core gives one-cycle pulses for executed sleep and
   watchdog-clear instructions, reset causes as levels or pulses, and a
   free-running watchdog RC oscillator level that is unrelated to CLK_IN.
*/
// Operation
// [R1] Plain timer counts on device clock
// [R2] Plain timer overflows every 65536 clocks
// [R3] Timer overflow clears timeout, no reset
// [R4] Watchdog-clear instruction sets timeout flag
// [R5] Plain timer holds during sleep
// [R6] Counter and postscaler not software accessible
// [R7] Watchdog chain doubles as power-up timer
// [R8] Sleep clears chain, powerdown, sets timeout
// [R9] Sleep stops oscillator, holds pins
// [R10] Watchdog reset internal, master clear undriven
// [R11] Resets and interrupts wake from sleep
// [R12] Only listed peripherals can wake
// [R13] Reset wake resets; interrupt wake resumes
// [R14] Powerdown set at power-up, cleared by sleep
// [R15] Watchdog timeout reset clears timeout flag
// [R16] Sleep prefetches next instruction
// [R17] Wake needs source enable, ignores global
// [R18] Vector after wake only if global enabled
// [R19] Pending enabled interrupt makes sleep wake immediately
// [R20] Watchdog counter cleared on every wake
// [R21] Crystal modes hold 1024 clocks on wake
// [R22] Software places no-op after sleep
// [R23] Postscale select sets watchdog mode
// [R24] Enabled watchdog overflow resets device
// [R25] RC oscillator domain synchronised before use
module wdsw_top #(
   parameter int WDT_CNT_W = 8
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // Reset causes and configuration
   input wire logic POWER_ON_IN,
   input wire logic BROWN_OUT_IN,
   input wire logic MASTER_CLEAR_IN,
   input wire wdsw_pkg::wdsw_cfg_t CFG_IN,
   // Core events
   input wire logic SLEEP_EXEC_IN,
   input wire logic WATCHDOG_CLEAR_INSTR_IN,
   input wire logic STACK_AVAILABLE_IN,
   input wire wdsw_pkg::wdsw_irq_t IRQ_IN,
   // Watchdog RC oscillator
   input wire logic WDT_OSC_IN,
   // Register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [7:0] REG_RDATA_OUT,
   // Core control
   output logic DEVICE_RESET_OUT,
   output logic CORE_HOLD_OUT,
   output logic SLEEP_OUT,
   output logic OSC_DRIVER_EN_OUT,
   output logic IO_HOLD_OUT,
   output logic PREFETCH_NEXT_OUT,
   output logic WAKE_RESUME_OUT,
   output logic VECTOR_REQ_OUT,
   output logic TIMER_OVF_OUT,
   output logic GLOBAL_IRQ_DISABLE_OUT
);

   wdsw_pkg::wdsw_state_t state_r;
   wdsw_pkg::wdsw_state_t state_nxt;
   logic [2:0] osc_sync_r;
   logic rc_tick;
   logic [15:0] cnt_r;
   logic [7:0] ps_r;
   logic [10:0] ost_r;
   logic timeout_flag_r;
   logic powerdown_flag_r;
   logic poweron_n_r;
   logic brownout_n_r;
   logic global_irq_disable_r;
   logic timer_mode;
   logic wd_mode;
   logic cnt_clear;
   logic cnt_adv;
   logic cnt_wrap;
   logic ps_done;
   logic wdt_timeout;
   logic timer_ovf;
   logic irq_pending;
   logic sleep_now;
   logic crystal;
   logic pwr_event;
   logic ext_reset;
   logic reg_wr_status;

   // Last postscaler index for a select code; shared by postscaler and timeout logic
   function automatic logic [7:0] ps_last(input logic [1:0] sel);
      logic [7:0] last;
      last = wdsw_pkg::PS_LAST_1;
      case (sel)
         wdsw_pkg::PS_SEL_256: last = wdsw_pkg::PS_LAST_256;
         wdsw_pkg::PS_SEL_64: last = wdsw_pkg::PS_LAST_64;
         default: last = wdsw_pkg::PS_LAST_1;
      endcase
      return last;
   endfunction

   // Low bits of the counter all ones: one watchdog counter period elapsed
   function automatic logic low_bits_full(input logic [15:0] c);
      logic full;
      full = &c[WDT_CNT_W-1:0];
      return full;
   endfunction

   // Mode decode from the postscale select field
   assign timer_mode = (CFG_IN.watchdog_postscale_select == wdsw_pkg::PS_SEL_TIMER); // R23
   assign wd_mode = !timer_mode; // R23
   assign crystal = (CFG_IN.osc_mode == wdsw_pkg::OSC_XT) ||
                    (CFG_IN.osc_mode == wdsw_pkg::OSC_LF);
   assign pwr_event = POWER_ON_IN || BROWN_OUT_IN;
   assign ext_reset = MASTER_CLEAR_IN;

   // Only the listed wake sources are wired in; others have no path here
   assign irq_pending = |(IRQ_IN.enable & IRQ_IN.flag); // R12 R17

   // Three flops on the RC level; only the second and third feed the edge detect
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         osc_sync_r <= 3'h0;
      end else begin
         osc_sync_r <= {osc_sync_r[1:0], WDT_OSC_IN}; // R25
      end
   end
   assign rc_tick = osc_sync_r[1] && !osc_sync_r[2]; // R25

   // Counter clock choice: device clock in plain timer run, none in its sleep, RC ticks in watchdog mode and power-up
   always_comb begin
      cnt_adv = 1'b0;
      case (state_r)
         wdsw_pkg::ST_POWERUP_DELAY_TIMER: cnt_adv = rc_tick; // R7
         wdsw_pkg::ST_RUN: cnt_adv = timer_mode ? 1'b1 : rc_tick; // R1
         wdsw_pkg::ST_SLEEP: cnt_adv = timer_mode ? 1'b0 : rc_tick; // R5
         default: cnt_adv = 1'b0;
      endcase
   end

   // Wrap points: full 16 bits as a plain timer, low bits as a watchdog
   assign cnt_wrap = cnt_adv && ((state_r != wdsw_pkg::ST_POWERUP_DELAY_TIMER && timer_mode) ?
                     (cnt_r == wdsw_pkg::TIMER_LAST) : low_bits_full(cnt_r)); // R2
   assign ps_done = (state_r == wdsw_pkg::ST_POWERUP_DELAY_TIMER) ?
                    (ps_r == wdsw_pkg::POWERUP_DELAY_TIMER_PS_LAST) :
                    (ps_r == ps_last(CFG_IN.watchdog_postscale_select));
   assign timer_ovf = cnt_wrap && timer_mode && (state_r == wdsw_pkg::ST_RUN); // R3
   assign wdt_timeout = cnt_wrap && wd_mode && ps_done &&
                        (state_r == wdsw_pkg::ST_RUN || state_r == wdsw_pkg::ST_SLEEP); // R24

   // Sleep is only entered when no enabled source is already flagged
   assign sleep_now = (state_r == wdsw_pkg::ST_RUN) && SLEEP_EXEC_IN;

   // Next state; resets always win over wake and sleep
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         wdsw_pkg::ST_POWERUP_DELAY_TIMER: begin
            if (cnt_wrap && ps_done) begin
               state_nxt = wdsw_pkg::ST_RUN; // R7
            end
         end
         wdsw_pkg::ST_RESET: begin
            if (!ext_reset) begin
               state_nxt = wdsw_pkg::ST_RUN;
            end
         end
         wdsw_pkg::ST_RUN: begin
            if (wdt_timeout) begin
               state_nxt = wdsw_pkg::ST_RESET; // R24
            end else if (SLEEP_EXEC_IN && !irq_pending) begin
               state_nxt = wdsw_pkg::ST_SLEEP;
            end
         end
         wdsw_pkg::ST_SLEEP: begin
            if (wdt_timeout) begin
               state_nxt = wdsw_pkg::ST_RESET; // R11 R13
            end else if (irq_pending) begin
               state_nxt = crystal ? wdsw_pkg::ST_OST : wdsw_pkg::ST_RUN; // R11 R21
            end
         end
         wdsw_pkg::ST_OST: begin
            if (ost_r == 11'(wdsw_pkg::OST_CYCLES - 1)) begin
               state_nxt = wdsw_pkg::ST_RUN; // R21
            end
         end
         default: state_nxt = wdsw_pkg::ST_POWERUP_DELAY_TIMER;
      endcase
      // Power events restart the power-up delay; master clear resets directly
      if (pwr_event) begin
         state_nxt = wdsw_pkg::ST_POWERUP_DELAY_TIMER; // R7 R11 R13
      end else if (ext_reset) begin
         state_nxt = wdsw_pkg::ST_RESET; // R11 R13
      end
   end

   // State register
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_r <= wdsw_pkg::ST_POWERUP_DELAY_TIMER;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Chain clears: reset state, entry to power-up delay, sleep, watchdog-clear, and leaving sleep
   assign cnt_clear = (state_r == wdsw_pkg::ST_RESET) || sleep_now ||
                      (state_r == wdsw_pkg::ST_RUN && WATCHDOG_CLEAR_INSTR_IN) ||
                      (state_r == wdsw_pkg::ST_SLEEP && state_nxt != wdsw_pkg::ST_SLEEP) ||
                      (state_r != wdsw_pkg::ST_POWERUP_DELAY_TIMER && state_nxt == wdsw_pkg::ST_POWERUP_DELAY_TIMER);

   // Watchdog counter; no software path reaches it
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         cnt_r <= 16'h0000;
      end else if (cnt_clear) begin
         cnt_r <= 16'h0000; // R8 R20
      end else if (cnt_wrap) begin
         cnt_r <= 16'h0000;
      end else if (cnt_adv) begin
         cnt_r <= cnt_r + 16'h0001; // R6
      end
   end

   // Postscaler counts watchdog periods; unused as a plain timer
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ps_r <= 8'h00;
      end else if (cnt_clear) begin
         ps_r <= 8'h00; // R8 R20
      end else if (cnt_wrap && (wd_mode || state_r == wdsw_pkg::ST_POWERUP_DELAY_TIMER)) begin
         ps_r <= ps_done ? 8'h00 : ps_r + 8'h01; // R7 R23
      end
   end

   // Start-up delay counter for crystal modes
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         ost_r <= 11'h000;
      end else if (state_r == wdsw_pkg::ST_OST) begin
         ost_r <= ost_r + 11'h001; // R21
      end else begin
         ost_r <= 11'h000;
      end
   end

   // Timeout flag; a hardware clear wins over a rearm in the same cycle
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         timeout_flag_r <= 1'b1;
      end else if (pwr_event) begin
         timeout_flag_r <= 1'b1;
      end else if (wdt_timeout || timer_ovf) begin
         timeout_flag_r <= 1'b0; // R3 R15
      end else if (sleep_now) begin
         timeout_flag_r <= 1'b1; // R8 R19
      end else if (state_r == wdsw_pkg::ST_RUN && WATCHDOG_CLEAR_INSTR_IN) begin
         timeout_flag_r <= 1'b1; // R4
      end
   end

   // Powerdown flag; master clear leaves it as it was
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         powerdown_flag_r <= 1'b1;
      end else if (pwr_event) begin
         powerdown_flag_r <= 1'b1; // R14
      end else if (state_r == wdsw_pkg::ST_RUN && WATCHDOG_CLEAR_INSTR_IN) begin
         powerdown_flag_r <= 1'b1;
      end else if (sleep_now) begin
         powerdown_flag_r <= 1'b0; // R8 R14 R19
      end
   end

   // Status write decode
   assign reg_wr_status = REG_WR_IN && (REG_ADDR_IN == wdsw_pkg::ADDR_CPU_STATUS_FLAGS);

   // Reset-cause bits: software sets them, the matching event clears and wins
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         poweron_n_r <= 1'b0;
         brownout_n_r <= 1'b1;
      end else begin
         if (POWER_ON_IN) begin
            poweron_n_r <= 1'b0;
         end else if (reg_wr_status && REG_WDATA_IN[wdsw_pkg::BIT_POWERON]) begin
            poweron_n_r <= 1'b1;
         end
         if (BROWN_OUT_IN) begin
            brownout_n_r <= 1'b0;
         end else if (reg_wr_status && REG_WDATA_IN[wdsw_pkg::BIT_BROWNOUT]) begin
            brownout_n_r <= 1'b1;
         end
      end
   end

   // Global interrupt disable: written by software, set by any reset
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         global_irq_disable_r <= wdsw_pkg::GLOBAL_IRQ_DISABLE_RST;
      end else if (pwr_event || ext_reset || wdt_timeout) begin
         global_irq_disable_r <= wdsw_pkg::GLOBAL_IRQ_DISABLE_RST;
      end else if (reg_wr_status) begin
         global_irq_disable_r <= REG_WDATA_IN[wdsw_pkg::BIT_GLOBAL_IRQ_DISABLE];
      end
   end

   // Read data one cycle after the strobe; counter and postscaler have no address
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= wdsw_pkg::UNMAPPED_READ;
      end else if (REG_RD_IN && REG_ADDR_IN == wdsw_pkg::ADDR_CPU_STATUS_FLAGS) begin
         REG_RDATA_OUT <= {2'h0, STACK_AVAILABLE_IN, global_irq_disable_r,
                           timeout_flag_r, powerdown_flag_r,
                           poweron_n_r, brownout_n_r}; // R6
      end else begin
         REG_RDATA_OUT <= wdsw_pkg::UNMAPPED_READ;
      end
   end

   // Reset and hold levels follow the next state so they line up with it;
   // the watchdog reset is an internal level only, master clear stays undriven
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         DEVICE_RESET_OUT <= 1'b1;
         CORE_HOLD_OUT <= 1'b1;
      end else begin
         DEVICE_RESET_OUT <= (state_nxt == wdsw_pkg::ST_POWERUP_DELAY_TIMER) ||
                             (state_nxt == wdsw_pkg::ST_RESET); // R10 R13
         CORE_HOLD_OUT <= (state_nxt != wdsw_pkg::ST_RUN); // R21
      end
   end

   // Sleep outputs: oscillator off and pins frozen while asleep
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         SLEEP_OUT <= 1'b0;
         OSC_DRIVER_EN_OUT <= 1'b1;
         IO_HOLD_OUT <= 1'b0;
      end else begin
         SLEEP_OUT <= (state_nxt == wdsw_pkg::ST_SLEEP);
         OSC_DRIVER_EN_OUT <= (state_nxt != wdsw_pkg::ST_SLEEP); // R9
         IO_HOLD_OUT <= (state_nxt == wdsw_pkg::ST_SLEEP); // R9
      end
   end

   // Event pulses toward the core
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         PREFETCH_NEXT_OUT <= 1'b0;
         WAKE_RESUME_OUT <= 1'b0;
         VECTOR_REQ_OUT <= 1'b0;
         TIMER_OVF_OUT <= 1'b0;
      end else begin
         PREFETCH_NEXT_OUT <= sleep_now && !wdt_timeout && !pwr_event && !ext_reset; // R16
         // Resume covers the wake itself and the immediate-wake case
         WAKE_RESUME_OUT <= !pwr_event && !ext_reset &&
            ((state_r == wdsw_pkg::ST_SLEEP && state_nxt == wdsw_pkg::ST_RUN) ||
             (state_r == wdsw_pkg::ST_OST && state_nxt == wdsw_pkg::ST_RUN) ||
             (sleep_now && irq_pending && !wdt_timeout)); // R13 R19
         // The core runs the prefetched instruction first, then takes the vector
         VECTOR_REQ_OUT <= !pwr_event && !ext_reset && !global_irq_disable_r &&
            ((state_r == wdsw_pkg::ST_SLEEP && state_nxt == wdsw_pkg::ST_RUN) ||
             (state_r == wdsw_pkg::ST_OST && state_nxt == wdsw_pkg::ST_RUN) ||
             (sleep_now && irq_pending && !wdt_timeout)); // R18
         TIMER_OVF_OUT <= timer_ovf && !pwr_event && !ext_reset; // R3
      end
   end

   // Mirror of the global disable for the interrupt logic
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         GLOBAL_IRQ_DISABLE_OUT <= wdsw_pkg::GLOBAL_IRQ_DISABLE_RST;
      end else if (pwr_event || ext_reset || wdt_timeout) begin
         GLOBAL_IRQ_DISABLE_OUT <= wdsw_pkg::GLOBAL_IRQ_DISABLE_RST;
      end else if (reg_wr_status) begin
         GLOBAL_IRQ_DISABLE_OUT <= REG_WDATA_IN[wdsw_pkg::BIT_GLOBAL_IRQ_DISABLE];
      end
   end

endmodule

//--- verification/wdsw_checker.sv
/*
   Port-level assertions for the watchdog, sleep and wake controller.
   Assumes one clock, synchronous active-low reset, bound to wdsw_top.
*/
module wdsw_checker #(
   parameter int WDT_CNT_W = 8
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic POWER_ON_IN,
   input wire logic BROWN_OUT_IN,
   input wire logic MASTER_CLEAR_IN,
   input wire wdsw_pkg::wdsw_cfg_t CFG_IN,
   input wire logic SLEEP_EXEC_IN,
   input wire wdsw_pkg::wdsw_irq_t IRQ_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   input wire logic DEVICE_RESET_OUT,
   input wire logic CORE_HOLD_OUT,
   input wire logic SLEEP_OUT,
   input wire logic OSC_DRIVER_EN_OUT,
   input wire logic IO_HOLD_OUT,
   input wire logic PREFETCH_NEXT_OUT,
   input wire logic WAKE_RESUME_OUT,
   input wire logic VECTOR_REQ_OUT,
   input wire logic TIMER_OVF_OUT,
   input wire logic GLOBAL_IRQ_DISABLE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend;
   logic quiet;
   logic fast_osc;
   logic [10:0] ost_n;
   // Reset causes excluded so that only instruction or interrupt effects are judged
   assign pend = |(IRQ_IN.enable & IRQ_IN.flag);
   assign quiet = !MASTER_CLEAR_IN && !POWER_ON_IN && !BROWN_OUT_IN && !DEVICE_RESET_OUT;
   assign fast_osc = CFG_IN.osc_mode inside {wdsw_pkg::OSC_RC, wdsw_pkg::OSC_EC};
   // Held outside reset and sleep: start-up delay only
   always_ff @(posedge CLK_IN) begin
      ost_n <= CORE_HOLD_OUT && !DEVICE_RESET_OUT && !SLEEP_OUT ? ost_n + 11'h001 : 11'h000;
   end

   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sleep_entry_a: assert property (SLEEP_EXEC_IN && !CORE_HOLD_OUT && !pend && quiet
      |=> SLEEP_OUT && PREFETCH_NEXT_OUT) else $error("sleep not entered");
   sleep_levels_a: assert property (SLEEP_OUT |-> IO_HOLD_OUT && !OSC_DRIVER_EN_OUT)
      else $error("sleep levels wrong");
   pending_wake_a: assert property (SLEEP_EXEC_IN && !CORE_HOLD_OUT && pend && quiet
      |=> WAKE_RESUME_OUT && !SLEEP_OUT) else $error("pending wake missed");
   irq_wake_a: assert property (SLEEP_OUT && pend && quiet && fast_osc
      |=> !SLEEP_OUT && WAKE_RESUME_OUT) else $error("wake missed");
   vector_gate_a: assert property ((WAKE_RESUME_OUT || VECTOR_REQ_OUT)
      |-> WAKE_RESUME_OUT && (VECTOR_REQ_OUT != GLOBAL_IRQ_DISABLE_OUT))
      else $error("vector request wrong");
   ost_hold_a: assert property ($fell(SLEEP_OUT) && quiet && !fast_osc
      |=> (CORE_HOLD_OUT && !WAKE_RESUME_OUT)[*8]) else $error("start-up delay wrong");
   ost_end_a: assert property (ost_n == 11'h000 || (ost_n == 11'h400) ==
      (WAKE_RESUME_OUT && !CORE_HOLD_OUT)) else $error("start-up length wrong");
   timer_no_reset_a: assert property (TIMER_OVF_OUT |-> !DEVICE_RESET_OUT ##1 !DEVICE_RESET_OUT)
      else $error("overflow reset");
   timer_sleep_hold_a: assert property (SLEEP_OUT |-> !TIMER_OVF_OUT)
      else $error("timer overflowed in sleep");
   unmapped_read_a: assert property ($past(REG_RD_IN)
      && $past(REG_ADDR_IN) != wdsw_pkg::ADDR_CPU_STATUS_FLAGS |-> REG_RDATA_OUT == 8'h00)
      else $error("unmapped read not zero");
   prefetch_pulse_a: assert property (PREFETCH_NEXT_OUT
      |-> $past(SLEEP_EXEC_IN) ##1 !PREFETCH_NEXT_OUT) else $error("prefetch pulse wrong");

   // Main scenarios reached
   cover property (SLEEP_EXEC_IN && !CORE_HOLD_OUT ##1 SLEEP_OUT);
   cover property (WAKE_RESUME_OUT && VECTOR_REQ_OUT);
   cover property (TIMER_OVF_OUT);
   cover property ($fell(SLEEP_OUT) && DEVICE_RESET_OUT);
endmodule

bind wdsw_top wdsw_checker #(.WDT_CNT_W(WDT_CNT_W)) chk_u (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .POWER_ON_IN(POWER_ON_IN),
   .BROWN_OUT_IN(BROWN_OUT_IN), .MASTER_CLEAR_IN(MASTER_CLEAR_IN), .CFG_IN(CFG_IN),
   .SLEEP_EXEC_IN(SLEEP_EXEC_IN), .IRQ_IN(IRQ_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .DEVICE_RESET_OUT(DEVICE_RESET_OUT),
   .CORE_HOLD_OUT(CORE_HOLD_OUT), .SLEEP_OUT(SLEEP_OUT), .OSC_DRIVER_EN_OUT(OSC_DRIVER_EN_OUT),
   .IO_HOLD_OUT(IO_HOLD_OUT), .PREFETCH_NEXT_OUT(PREFETCH_NEXT_OUT),
   .WAKE_RESUME_OUT(WAKE_RESUME_OUT), .VECTOR_REQ_OUT(VECTOR_REQ_OUT),
   .TIMER_OVF_OUT(TIMER_OVF_OUT), .GLOBAL_IRQ_DISABLE_OUT(GLOBAL_IRQ_DISABLE_OUT)
);

//--- verification/wdsw_top_test.sv
/*
   Self-checking bench for the watchdog, sleep and wake controller.
   Assumes a 10 MHz clock, a slow free-running watchdog oscillator and
   a short watchdog counter so that power-up and timeouts stay brief.
*/
module wdsw_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, mclr, slp, wclr, osc, rd, wr;
   wdsw_pkg::wdsw_cfg_t cfg;
   wdsw_pkg::wdsw_irq_t irq;
   logic [7:0] addr, wdata, d, rdata;
   logic dev_rst, hold, sleep_o, osc_en, io_hold, prefetch, resume, vector, tovf, gid;
   int miscompares = 0;
   int comparisons = 0;
   int n;

   wdsw_top #(.WDT_CNT_W(2)) dut_u (
      .CLK_IN(clk), .RST_N_IN(rst_n), .POWER_ON_IN(1'b0), .BROWN_OUT_IN(1'b0),
      .MASTER_CLEAR_IN(mclr), .CFG_IN(cfg), .SLEEP_EXEC_IN(slp), .WATCHDOG_CLEAR_INSTR_IN(wclr),
      .STACK_AVAILABLE_IN(1'b1), .IRQ_IN(irq), .WDT_OSC_IN(osc), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .DEVICE_RESET_OUT(dev_rst), .CORE_HOLD_OUT(hold), .SLEEP_OUT(sleep_o),
      .OSC_DRIVER_EN_OUT(osc_en), .IO_HOLD_OUT(io_hold), .PREFETCH_NEXT_OUT(prefetch),
      .WAKE_RESUME_OUT(resume), .VECTOR_REQ_OUT(vector), .TIMER_OVF_OUT(tovf),
      .GLOBAL_IRQ_DISABLE_OUT(gid)
   );

   // Device clock; the slower watchdog oscillator only meets its falling edges
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      forever #400 osc = ~osc;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic sleep_cmd;
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      #1;
   endtask

   task automatic clr_cmd;
      @(posedge clk);
      wclr <= 1'b1;
      @(posedge clk);
      wclr <= 1'b0;
   endtask

   // Bounded waits, so a stuck design cannot hang the run
   task automatic wait_run(input int max);
      n = 0;
      while (hold !== 1'b0 && n < max) begin
         @(posedge clk);
         #1 n++;
      end
      chk("core released", hold, 1'b0);
   endtask

   task automatic wait_reset(input int max);
      n = 0;
      while (dev_rst !== 1'b1 && n < max) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0; mclr = 1'b0; slp = 1'b0; wclr = 1'b0; rd = 1'b0; wr = 1'b0;
      addr = 8'h00; wdata = 8'h00; irq = '0;
      cfg = {wdsw_pkg::OSC_RC, wdsw_pkg::PS_SEL_1};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (200) @(posedge clk);
      #1 chk("powerup hold", dev_rst, 1'b1);
      wait_run(200);
      clr_cmd;
      rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
      chk("status after powerup", d & 8'h3C, 8'h3C);
      rd_reg(8'h07, d);
      chk("unmapped read", d, 8'h00);
      // Every wake source, alternating the global disable
      for (int i = 0; i < wdsw_pkg::WAKE_SRC_N; i++) begin
         clr_cmd;
         wr_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, 8'(i % 2) << 4);
         sleep_cmd;
         chk("asleep", sleep_o, 1'b1);
         chk("prefetch", prefetch, 1'b1);
         chk("osc stopped", osc_en, 1'b0);
         chk("io held", io_hold, 1'b1);
         @(posedge clk);
         irq <= {9'h000, 9'(1 << i)};
         repeat (3) @(posedge clk);
         #1 chk("disabled source", sleep_o, 1'b1);
         @(posedge clk);
         irq <= {9'(1 << i), 9'(1 << i)};
         @(posedge clk);
         #1 chk("resume", resume, 1'b1);
         chk("vector", vector, 1'(i % 2 == 0));
         chk("awake", sleep_o, 1'b0);
         @(posedge clk);
         irq <= '0;
         rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
         chk("flags after sleep", d & 8'h0C, 8'h08);
      end
      // Interrupt already pending when sleep executes
      clr_cmd;
      @(posedge clk);
      irq <= {9'h001, 9'h001};
      sleep_cmd;
      chk("pending wake", resume, 1'b1);
      chk("no sleep", sleep_o, 1'b0);
      @(posedge clk);
      irq <= '0;
      rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
      chk("flags pending", d & 8'h0C, 8'h08);
      // Watchdog timeout while asleep
      clr_cmd;
      sleep_cmd;
      wait_reset(100);
      chk("timeout in sleep", dev_rst, 1'b1);
      chk("woken by timeout", sleep_o, 1'b0);
      wait_run(50);
      rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
      chk("flags after timeout", d & 8'h1C, 8'h10);
      // Regular clears hold the watchdog off, then it is left to expire
      n = 0;
      repeat (8) begin
         clr_cmd;
         repeat (16) begin
            @(posedge clk);
            #1 if (dev_rst === 1'b1) n++;
         end
      end
      chk("cleared watchdog quiet", n, 32'd0);
      wait_reset(100);
      chk("timeout in run", dev_rst, 1'b1);
      wait_run(50);
      // Master clear while asleep
      clr_cmd;
      sleep_cmd;
      @(posedge clk);
      mclr <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("mclr reset", dev_rst, 1'b1);
      chk("mclr wake", sleep_o, 1'b0);
      @(posedge clk);
      mclr <= 1'b0;
      wait_run(50);
      rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
      chk("flags after mclr", d & 8'h0C, 8'h08);
      // Crystal oscillator and plain timer mode, set up under reset
      @(posedge clk);
      rst_n <= 1'b0;
      cfg <= {wdsw_pkg::OSC_XT, wdsw_pkg::PS_SEL_TIMER};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      wait_run(400);
      clr_cmd;
      sleep_cmd;
      @(posedge clk);
      irq <= {9'h002, 9'h002};
      n = 0;
      while (resume !== 1'b1 && n < 1100) begin
         @(posedge clk);
         #1 n++;
      end
      chk("start-up delay", n >= 1023 && n <= 1027, 1'b1);
      chk("core released after delay", hold, 1'b0);
      @(posedge clk);
      irq <= '0;
      clr_cmd;
      n = 0;
      while (tovf !== 1'b1 && n < 66000) begin
         @(posedge clk);
         #1 n++;
      end
      chk("timer period", n >= 65535 && n <= 65537, 1'b1);
      chk("no reset on overflow", dev_rst, 1'b0);
      rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
      chk("timeout cleared", d & 8'h08, 8'h00);
      clr_cmd;
      rd_reg(wdsw_pkg::ADDR_CPU_STATUS_FLAGS, d);
      chk("timeout rearmed", d & 8'h08, 8'h08);
      give_verdict;
   end

   // The tests need about 70000 cycles; allow some margin
   initial begin
      #(90000 * 100);
      miscompares++;
      give_verdict;
   end
endmodule
